// ### design/ucr_pkg.sv
// Constants, states and field positions of the user configuration register.
// Assumes nothing; imported by ucr_top, ucr_host and testbench, not by ucr_sync or ucr_toggle_rx.
package ucr_pkg;
   // Serial link addressing and command codes
   localparam logic [6:0] UCR_SLAVE_ADDR = 7'h40;
   localparam logic [7:0] UCR_CMD_WRITE_CFG = 8'he6;
   localparam logic [7:0] UCR_CMD_READ_CFG = 8'he7;
   localparam logic [7:0] UCR_CMD_RESET = 8'hfe;
   ////////////////////////////////////////////////////////////////////////////////
   // Register layout
   localparam logic [7:0] UCR_CFG_RESET = 8'h3a;
   localparam logic [7:0] UCR_RESERVED_BITS_MASK = 8'h3a;
   localparam logic [7:0] UCR_WR_MASK = 8'h85;
   localparam int UCR_RES_HI_BIT = 7;
   localparam int UCR_SUPPLY_BIT = 6;
   localparam int UCR_HEATER_BIT = 2;
   localparam int UCR_RES_LO_BIT = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Bit counter and link clear timing
   localparam logic [3:0] UCR_BIT_ACK = 4'h8;
   localparam logic [3:0] UCR_BIT_STEP = 4'h1;
   localparam logic [1:0] UCR_CLR_LEN = 2'h2;
   localparam logic [1:0] UCR_CLR_STEP = 2'h1;
   // Byte phases of one frame on the link
   typedef enum logic [2:0] {
      UCR_PH_ADDR = 3'b000,
      UCR_PH_CMD = 3'b001,
      UCR_PH_WDATA = 3'b010,
      UCR_PH_SEND = 3'b011,
      UCR_PH_IDLE = 3'b100
   } ucr_phase_t;
endpackage

// ### design/ucr_sync.sv
// Two-flop level synchroniser, W bits wide.
// Assumes its input is quasi-static per bit; no bus coherence across bits.
`timescale 1ns/1ps
`default_nettype none
module ucr_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] dout_q;
   logic [W-1:0] dout_d;

   always_comb begin
      meta_d = din;
      dout_d = meta_q;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_q <= '0;
         dout_q <= '0;
      end else begin
         meta_q <= meta_d;
         dout_q <= dout_d;
      end
   end

   assign dout = dout_q;
endmodule
`default_nettype wire

// ### design/ucr_toggle_rx.sv
// Turns a toggle from another clock domain into a one-cycle pulse.
// Assumes the far side toggles no faster than once per three local cycles.
`timescale 1ns/1ps
`default_nettype none
module ucr_toggle_rx (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Event
   input wire logic tgl_in,
   output logic pulse
);
   logic tgl_s;
   logic last_q;
   logic last_d;
   logic pulse_q;
   logic pulse_d;

   ucr_sync #(.W(1)) u_sync (
      .clk(clk),
      .rstn(rstn),
      .din(tgl_in),
      .dout(tgl_s)
   );

   always_comb begin
      last_d = tgl_s;
      pulse_d = tgl_s ^ last_q;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         last_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         last_q <= last_d;
         pulse_q <= pulse_d;
      end
   end

   assign pulse = pulse_q;
endmodule
`default_nettype wire

// ### design/ucr_top.sv
// User configuration register of the sensor, with its serial slave port.
// Assumes scl/sda come from a bus master; sda is open drain, pulled up outside.
`timescale 1ns/1ps
`default_nettype none
module ucr_top
   import ucr_pkg::*;
(
   // System clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Serial link
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Supply monitor
   input wire logic supply_low,
   // Measurement sequencer
   input wire logic meas_start,
   output logic [1:0] meas_resolution,
   // Configuration outputs
   output logic [1:0] resolution_select,
   output logic heater_on
);
   ////////////////////////////////////////////////////////////////////////////////
   // System domain signals
   logic scl_s;
   logic sda_s;
   logic supply_s;
   logic wr_pulse;
   logic rst_pulse;
   logic scl_p_q, scl_p_d;
   logic sda_p_q, sda_p_d;
   logic busy_q, busy_d;
   logic [1:0] clr_cnt_q, clr_cnt_d;
   logic link_clr_q, link_clr_d;
   logic link_por_q, link_por_d;
   logic [7:0] cfg_q, cfg_d;
   logic [7:0] snap_q, snap_d;
   logic [7:0] rd_val;
   logic [1:0] res_q, res_d;
   logic [1:0] meas_res_q, meas_res_d;
   logic heater_q, heater_d;
   logic sda_o_q, sda_o_d;
   logic start_det;
   logic stop_det;
   // Link domain signals
   ucr_phase_t ph_q, ph_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic [7:0] wdata_q, wdata_d;
   logic wr_tgl_q, wr_tgl_d;
   logic rst_tgl_q, rst_tgl_d;
   logic ack_ok;
   logic oe_q, oe_d;

   ////////////////////////////////////////////////////////////////////////////////
   // Crossings into the system domain
   ucr_sync #(.W(3)) u_pin_sync (
      .clk(sys_clk),
      .rstn(rstn),
      .din({scl, sda_i, supply_low}),
      .dout({scl_s, sda_s, supply_s})
   );

   ucr_toggle_rx u_wr_rx (
      .clk(sys_clk),
      .rstn(rstn),
      .tgl_in(wr_tgl_q),
      .pulse(wr_pulse)
   );

   ucr_toggle_rx u_rst_rx (
      .clk(sys_clk),
      .rstn(rstn),
      .tgl_in(rst_tgl_q),
      .pulse(rst_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Frame detection and link clear
   assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // Link clear is asserted while scl is high, so no scl edge meets its release
   always_comb begin
      scl_p_d = scl_s;
      sda_p_d = sda_s;
      busy_d = busy_q;
      clr_cnt_d = clr_cnt_q;
      if (start_det) begin
         busy_d = 1'b1;
      end else if (stop_det) begin
         busy_d = 1'b0;
      end
      if (start_det || stop_det) begin
         clr_cnt_d = UCR_CLR_LEN;
      end else if (clr_cnt_q != '0) begin
         clr_cnt_d = clr_cnt_q - UCR_CLR_STEP;
      end
      link_clr_d = (clr_cnt_q != '0);
      link_por_d = 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         busy_q <= 1'b0;
         clr_cnt_q <= '0;
         link_clr_q <= 1'b1;
         link_por_q <= 1'b1;
      end else begin
         scl_p_q <= scl_p_d;
         sda_p_q <= sda_p_d;
         busy_q <= busy_d;
         clr_cnt_q <= clr_cnt_d;
         link_clr_q <= link_clr_d | link_por_q;
         link_por_q <= link_por_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration register
   // Only writable bits are stored; reserved ones are forced on read
   assign rd_val = (cfg_q & UCR_WR_MASK) | UCR_RESERVED_BITS_MASK
      | (8'(supply_s) << UCR_SUPPLY_BIT);

   always_comb begin
      cfg_d = cfg_q;
      if (rst_pulse) begin
         cfg_d = UCR_CFG_RESET & UCR_WR_MASK;
      end else if (wr_pulse) begin
         cfg_d = wdata_q & UCR_WR_MASK;
      end
      // Snapshot frozen during a frame so the link reads a stable byte
      snap_d = busy_q ? snap_q : rd_val;
      res_d = {cfg_q[UCR_RES_HI_BIT], cfg_q[UCR_RES_LO_BIT]};
      heater_d = cfg_q[UCR_HEATER_BIT];
      meas_res_d = meas_start ? res_q : meas_res_q;
      sda_o_d = 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cfg_q <= UCR_CFG_RESET & UCR_WR_MASK;
         snap_q <= UCR_CFG_RESET;
         res_q <= '0;
         heater_q <= 1'b0;
         meas_res_q <= '0;
         sda_o_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         snap_q <= snap_d;
         res_q <= res_d;
         heater_q <= heater_d;
         meas_res_q <= meas_res_d;
         sda_o_q <= sda_o_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain: byte engine on rising scl
   always_comb begin
      case (ph_q)
         UCR_PH_ADDR: ack_ok = (sh_q[7:1] == UCR_SLAVE_ADDR);
         UCR_PH_CMD: ack_ok = (sh_q == UCR_CMD_WRITE_CFG) || (sh_q == UCR_CMD_READ_CFG)
            || (sh_q == UCR_CMD_RESET);
         UCR_PH_WDATA: ack_ok = 1'b1;
         default: ack_ok = 1'b0;
      endcase
   end

   always_comb begin
      ph_d = ph_q;
      bit_d = bit_q + UCR_BIT_STEP;
      sh_d = {sh_q[6:0], sda_i};
      wdata_d = wdata_q;
      wr_tgl_d = wr_tgl_q;
      rst_tgl_d = rst_tgl_q;
      if (bit_q == UCR_BIT_ACK) begin
         bit_d = '0;
         sh_d = sh_q;
         case (ph_q)
            UCR_PH_ADDR: begin
               if (!ack_ok) begin
                  ph_d = UCR_PH_IDLE;
               end else if (sh_q[0]) begin
                  ph_d = UCR_PH_SEND;
               end else begin
                  ph_d = UCR_PH_CMD;
               end
            end
            UCR_PH_CMD: begin
               ph_d = UCR_PH_IDLE;
               if (sh_q == UCR_CMD_WRITE_CFG) begin
                  ph_d = UCR_PH_WDATA;
               end else if (sh_q == UCR_CMD_RESET) begin
                  rst_tgl_d = ~rst_tgl_q;
               end
            end
            UCR_PH_WDATA: begin
               wdata_d = sh_q;
               wr_tgl_d = ~wr_tgl_q;
               ph_d = UCR_PH_IDLE;
            end
            UCR_PH_SEND: ph_d = UCR_PH_IDLE;
            default: ph_d = UCR_PH_IDLE;
         endcase
      end
   end

   always_ff @(posedge scl or posedge link_clr_q) begin
      if (link_clr_q) begin
         ph_q <= UCR_PH_ADDR;
         bit_q <= '0;
         sh_q <= '0;
      end else begin
         ph_q <= ph_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
      end
   end

   // Held across frames; a clear here would fake an event at the far side
   always_ff @(posedge scl or posedge link_por_q) begin
      if (link_por_q) begin
         wdata_q <= '0;
         wr_tgl_q <= 1'b0;
         rst_tgl_q <= 1'b0;
      end else begin
         wdata_q <= wdata_d;
         wr_tgl_q <= wr_tgl_d;
         rst_tgl_q <= rst_tgl_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain: data line drive on falling scl
   always_comb begin
      oe_d = 1'b0;
      if (bit_q == UCR_BIT_ACK) begin
         oe_d = ack_ok;
      end else if (ph_q == UCR_PH_SEND) begin
         oe_d = ~snap_q[~bit_q[2:0]];
      end
   end

   always_ff @(negedge scl or posedge link_clr_q) begin
      if (link_clr_q) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign sda_o = sda_o_q;
   assign sda_oe = oe_q;
   assign meas_resolution = meas_res_q;
   assign resolution_select = res_q;
   assign heater_on = heater_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_cfg_written;
      wr_pulse ##1 !rst_pulse;
   endsequence

   property p_write_lands(int pos_a, int pos_b);
      @(posedge sys_clk) disable iff (!rstn)
      s_cfg_written |=> ({res_q, heater_q} ==
         {$past(wdata_q[UCR_RES_HI_BIT], 2), $past(wdata_q[UCR_RES_LO_BIT], 2),
          $past(wdata_q[UCR_HEATER_BIT], 2)});
   endproperty

   chk_reset_value: assert property (@(posedge sys_clk)
      $rose(rstn) |-> (cfg_q == (UCR_CFG_RESET & UCR_WR_MASK)) && (snap_q == UCR_CFG_RESET))
      else $error("config not at reset value after reset");

   chk_reset_cmd: assert property (@(posedge sys_clk) disable iff (!rstn)
      rst_pulse |-> ##2 (res_q == '0) && !heater_q)
      else $error("reset command did not restore config");

   chk_write_fields: assert property (p_write_lands(0, 0))
      else $error("written resolution or heater not applied");

   chk_reserved_bits_ones: assert property (@(negedge scl) disable iff (link_clr_q)
      (ph_q == UCR_PH_SEND && bit_q != UCR_BIT_ACK && UCR_RESERVED_BITS_MASK[~bit_q[2:0]]) |=> !oe_q)
      else $error("reserved bit not returned as one");

   chk_supply_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!busy_q ##1 !busy_q) |-> snap_q[UCR_SUPPLY_BIT] == $past(supply_s))
      else $error("supply flag does not track supply monitor");

   chk_meas_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
      !meas_start |=> $stable(meas_res_q))
      else $error("measurement resolution changed without a start");

   chk_meas_take: assert property (@(posedge sys_clk) disable iff (!rstn)
      meas_start |=> meas_res_q == $past(res_q))
      else $error("measurement start did not take current resolution");

   chk_no_checksum: assert property (@(posedge scl) disable iff (link_clr_q)
      (ph_q == UCR_PH_SEND && bit_q == UCR_BIT_ACK) |=> ph_q == UCR_PH_IDLE)
      else $error("link continued after returned byte");

   chk_addr_nack: assert property (@(negedge scl) disable iff (link_clr_q)
      (ph_q == UCR_PH_ADDR && bit_q == UCR_BIT_ACK && sh_q[7:1] != UCR_SLAVE_ADDR)
      |=> !oe_q)
      else $error("acknowledged a foreign address");

   chk_read_drive: assert property (@(negedge scl) disable iff (link_clr_q)
      (ph_q == UCR_PH_SEND && bit_q != UCR_BIT_ACK) |=> oe_q == ~$past(snap_q[~bit_q[2:0]]))
      else $error("returned bit does not match register");
endmodule
`default_nettype wire

// ### tb/ucr_host.sv
// Host model: serial bus master that reads and writes the configuration register.
// Assumes a pull-up on sda outside; scl stands high between frames, 160 ns period inside.
`timescale 1ns/1ps
`default_nettype none
module ucr_host
   import ucr_pkg::*;
(
   // Serial link
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Odd offset keeps scl edges off the system clock grid
   task automatic start_cond();
      #3.7 sda_pull = 1'b0;
      #40 scl = 1'b1;
      #80 sda_pull = 1'b1;
      #80 scl = 1'b0;
   endtask
   task automatic stop_cond();
      #40 sda_pull = 1'b1;
      #40 scl = 1'b1;
      #80 sda_pull = 1'b0;
      #400;
   endtask
   // Nine bits MSB first; a 1 in tx releases the line
   task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         #40 sda_pull = ~tx[i];
         #40 scl = 1'b1;
         #40 rx[i] = sda;
         #40 scl = 1'b0;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic send_frame(input logic [6:0] addr, input logic [7:0] cmd,
         input logic has_data, input logic [7:0] data, output logic [2:0] ack);
      logic [8:0] rx;
      ack = 3'h0;
      start_cond();
      byte_io({addr, 1'b0, 1'b1}, rx);
      ack[2] = ~rx[0];
      if (ack[2]) begin
         byte_io({cmd, 1'b1}, rx);
         ack[1] = ~rx[0];
         if (has_data) begin
            byte_io({data, 1'b1}, rx);
            ack[0] = ~rx[0];
         end
      end
      stop_cond();
   endtask
   // With more set the host acks the byte and clocks one more
   task automatic read_frame(input logic [6:0] addr, input logic more,
         output logic [7:0] data, output logic [7:0] extra, output logic [2:0] ack);
      logic [8:0] rx;
      start_cond();
      byte_io({addr, 1'b0, 1'b1}, rx);
      ack[2] = ~rx[0];
      byte_io({UCR_CMD_READ_CFG, 1'b1}, rx);
      ack[1] = ~rx[0];
      start_cond();
      byte_io({addr, 1'b1, 1'b1}, rx);
      ack[0] = ~rx[0];
      byte_io({8'hff, ~more}, rx);
      data = rx[8:1];
      extra = 8'hff;
      if (more) begin
         byte_io(9'h1ff, rx);
         extra = rx[8:1];
      end
      stop_cond();
   endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench of the configuration register through its serial port.
// Assumes ucr_top and the host model; sda is pulled up here.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import ucr_pkg::*;
;
   logic sys_clk, rstn, supply_low, meas_start, scl, host_pull, sda_o, sda_oe, heater_on;
   logic [1:0] meas_resolution, resolution_select;
   logic [31:0] seed = 32'h0000d462;
   int n_mismatch = 0;
   int checks = 0;
   wire sda;
   assign sda = (host_pull | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;
   ucr_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .scl(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .supply_low(supply_low), .meas_start(meas_start),
      .meas_resolution(meas_resolution), .resolution_select(resolution_select),
      .heater_on(heater_on));
   ucr_host i_host (.scl(scl), .sda_pull(host_pull), .sda(sda));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [7:0] exp_cfg(input logic [7:0] d, input logic sup);
      return (d & UCR_WR_MASK) | UCR_RESERVED_BITS_MASK | {1'b0, sup, 6'h00};
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic pulse_meas();
      @(negedge sys_clk) meas_start = 1'b1;
      @(negedge sys_clk) meas_start = 1'b0;
      @(negedge sys_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // About twice the expected run time
   initial begin
      #500000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      logic [7:0] rd, ex, d, cur;
      logic [2:0] ack;
      logic [7:0] corner [6];
      corner = '{8'h00, 8'hff, 8'h81, 8'h80, 8'h01, 8'h04};
      rstn = 1'b0;
      supply_low = 1'b0;
      meas_start = 1'b0;
      repeat (8) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (6) @(negedge sys_clk);
      i_host.read_frame(UCR_SLAVE_ADDR, 1'b0, rd, ex, ack);
      check(rd, 8'h3a);
      check({5'h0, ack}, 8'h07);
      check({5'h0, resolution_select, heater_on}, 8'h00);
      // Host acks the byte: a checksum would show up here
      @(negedge sys_clk) supply_low = 1'b1;
      repeat (10) @(negedge sys_clk);
      i_host.read_frame(UCR_SLAVE_ADDR, 1'b1, rd, ex, ack);
      check(rd, 8'h7a);
      check(ex, 8'hff);
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         @(negedge sys_clk) supply_low = seed[8];
         repeat (10) @(negedge sys_clk);
         i_host.read_frame(UCR_SLAVE_ADDR, 1'b0, rd, ex, ack);
         d = (seed[7:0] & ~UCR_RESERVED_BITS_MASK) | (rd & UCR_RESERVED_BITS_MASK);
         // Corners other than 8'hff write reserved bits as zero on purpose
         d = (i < 6) ? corner[i] : d;
         i_host.send_frame(UCR_SLAVE_ADDR, UCR_CMD_WRITE_CFG, 1'b1, d, ack);
         check({5'h0, ack}, 8'h07);
         i_host.read_frame(UCR_SLAVE_ADDR, 1'b0, rd, ex, ack);
         check(rd, exp_cfg(d, seed[8]));
         @(negedge sys_clk);
         check({6'h0, resolution_select}, {6'h0, d[7], d[0]});
         check({7'h0, heater_on}, {7'h0, d[2]});
      end
      cur = d;
      i_host.send_frame(UCR_SLAVE_ADDR + 7'h01, UCR_CMD_WRITE_CFG, 1'b1, ~d, ack);
      check({5'h0, ack}, 8'h00);
      i_host.read_frame(UCR_SLAVE_ADDR, 1'b0, rd, ex, ack);
      check(rd, exp_cfg(cur, supply_low));
      // All writable bits set, so the reset command has something to clear
      i_host.send_frame(UCR_SLAVE_ADDR, UCR_CMD_WRITE_CFG, 1'b1, 8'hff, ack);
      @(negedge sys_clk);
      check({7'h0, heater_on}, 8'h01);
      i_host.send_frame(UCR_SLAVE_ADDR, UCR_CMD_RESET, 1'b0, 8'h00, ack);
      check({5'h0, ack}, 8'h06);
      @(negedge sys_clk) supply_low = 1'b0;
      repeat (10) @(negedge sys_clk);
      i_host.read_frame(UCR_SLAVE_ADDR, 1'b0, rd, ex, ack);
      check(rd, 8'h3a);
      check({5'h0, resolution_select, heater_on}, 8'h00);
      // New resolution waits for the next measurement start
      i_host.send_frame(UCR_SLAVE_ADDR, UCR_CMD_WRITE_CFG, 1'b1, 8'h81, ack);
      pulse_meas();
      check({6'h0, meas_resolution}, 8'h03);
      i_host.send_frame(UCR_SLAVE_ADDR, UCR_CMD_WRITE_CFG, 1'b1, 8'h80, ack);
      @(negedge sys_clk);
      check({6'h0, meas_resolution}, 8'h03);
      pulse_meas();
      check({6'h0, meas_resolution}, 8'h02);
      wrap_up();
   end
endmodule
`default_nettype wire
